//--- efpd_mcu_model.sv
// spi microcontroller model for the register port
`timescale 1ns/1ps
module efpd_mcu_model (
    input wire logic clock, // system clock
    output logic spi_sclk, // spi clock
    output logic spi_cs_n, // select
    output logic spi_mosi, // data out
    input wire logic spi_miso, // data in
    input wire logic spi_miso_oe_n // low while driven
);
    logic line_r = 1'b0;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // a released miso shows no stale bit
    always @(negedge clock) line_r <= spi_miso_oe_n ? ~line_r : spi_miso;
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic open_frame();
        hold(1);
        spi_cs_n = 1'b0;
        hold(6);
    endtask
    task automatic close_frame();
        hold(6);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        hold(10);
    endtask
    // six-clock half periods clear the three-clock pin sync
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            hold(6);
            rx[i] = line_r;
            spi_sclk = 1'b1;
            hold(6);
            spi_sclk = 1'b0;
        end
    endtask
endmodule // efpd_mcu_model

//--- efpd_pkg.sv
// constants for the event flag and process data register slice
package efpd_pkg;
    localparam logic [6:0] EFPD_ADDR_WDG_CODE = 7'h2a;
    localparam logic [6:0] EFPD_ADDR_STATUS_DEF = 7'h2b;
    localparam logic [6:0] EFPD_ADDR_STATUS_CODE = 7'h2c;
    localparam logic [6:0] EFPD_ADDR_EVENT_CODE_LOW = 7'h2f;
    localparam logic [6:0] EFPD_ADDR_EVENT_FLAG = 7'h30;
    localparam logic [6:0] EFPD_ADDR_INPUT_PROCESS_DATA_PORT = 7'h35;
    localparam logic [6:0] EFPD_ADDR_PD_VALIDITY = 7'h36;
    localparam logic [6:0] EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT = 7'h37;
    localparam int EFPD_BIT_EVENT_FLAG = 0;
    localparam int EFPD_BIT_WDG_ENABLE = 1;
    localparam int EFPD_BIT_PD_INVALID = 0;
    localparam int EFPD_SPI_RW_BIT = 7;
    localparam logic [7:0] EFPD_RESET_BYTE = 8'h00;
    localparam int EFPD_FIFO_DEPTH = 32;
    localparam int EFPD_PTR_W = 5;
    typedef enum logic {EFPD_SPI_ADDR, EFPD_SPI_DATA} efpd_spi_state_t;
endpackage

//--- efpd_regs.sv
// event flag, watchdog event and process data registers behind an spi slave
`timescale 1ns/1ps
// Operation
// - low event code octet is an 8-bit read/write register, reset zero.
// - watchdog expiry with enable clear leaves status code and event flag untouched.
// - watchdog expiry with enable set loads watchdog code into status code, sets flag.
// - event flag travels in the checksum/status octet of every reply.
// - event flag 1 means pending event, 0 none; resets to zero.
// - master write to the status code register clears the event flag.
// - each byte written to input data port enters input buffer unless it is full; reads return zero.
// - burst write to input data port keeps address fixed, all bytes to buffer.
// - validity bit is copied into the checksum/status octet invalid bit.
// - while invalid bit is 1 and pin routing is clear, input data bytes go to master as zero.
// - with pin routing set, input data follows the aux pin, never forced zero.
// - read-only output data port pops bytes received from master, reset zero.
// - burst read of output data port keeps address fixed, returns successive bytes.
// - event memory byte zero is default code when flag clear, status code otherwise.
// - software-written 8-bit watchdog event code is held for watchdog expiry.
module efpd_regs (
    input wire logic clock, // 20 MHz system clock
    input wire logic reset_n, // async reset, active low
    input wire logic spi_sclk, // spi clock pin, mode 0
    input wire logic spi_cs_n, // spi chip select pin, active low
    input wire logic spi_mosi, // spi data in pin
    output logic spi_miso, // spi data out pin
    output logic spi_miso_oe_n, // miso enable, low while driving
    input wire logic aux_pin_one, // aux pin level
    input wire logic pin_to_input_data_route, // route aux pin into input data
    input wire logic watchdog_expired, // watchdog expiry pulse
    input wire logic master_status_wr, // master writes status code, pulse
    input wire logic [7:0] master_status_data, // data of that write
    input wire logic input_data_pop, // link takes one input data byte, pulse
    output logic [7:0] input_process_data_byte, // byte taken by last pop
    output logic input_data_empty, // input buffer empty
    input wire logic output_data_push, // link delivers an output data byte, pulse
    input wire logic [7:0] output_process_data_byte, // byte delivered
    output logic output_data_full, // output buffer full
    output logic cks_event_flag, // checksum/status event bit
    output logic cks_pd_invalid, // checksum/status process data invalid bit
    output logic [7:0] event_memory_byte0, // answer for event memory address zero
    output logic [7:0] event_code_low_octet // low event code octet
);
    import efpd_pkg::*;

    logic rst_meta_r, rst_sync_n_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // pins: two stages, then a third stage used only for edge detection
    logic [3:0] pin_meta_r, pin_sync_r;
    logic sclk_old_r;
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            pin_meta_r <= 4'h1;
            pin_sync_r <= 4'h1;
            sclk_old_r <= 1'b0;
        end else begin
            pin_meta_r <= {aux_pin_one, spi_mosi, spi_sclk, spi_cs_n};
            pin_sync_r <= pin_meta_r;
            sclk_old_r <= pin_sync_r[1];
        end
    end
    logic cs_act, sclk_rise, sclk_fall, mosi_s, aux_s;
    assign cs_act = !pin_sync_r[0];
    assign sclk_rise = pin_sync_r[1] && !sclk_old_r;
    assign sclk_fall = !pin_sync_r[1] && sclk_old_r;
    assign mosi_s = pin_sync_r[2];
    assign aux_s = pin_sync_r[3];

    efpd_spi_state_t st_r, st_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt, load_pend_r, load_pend_nxt;
    logic byte_done, wr_stb, rd_load;
    logic [7:0] byte_in, rd_data;

    logic [7:0] event_low_r, event_low_nxt, wdg_code_r, wdg_code_nxt, status_def_r, status_def_nxt;
    logic [7:0] status_r, status_nxt, input_process_data_out_r, input_process_data_out_nxt;
    logic flag_r, flag_nxt, wdg_en_r, wdg_en_nxt, invalid_r, invalid_nxt;

    logic [7:0] input_process_data_mem [EFPD_FIFO_DEPTH];
    logic [7:0] output_process_data_mem [EFPD_FIFO_DEPTH];
    logic [EFPD_PTR_W:0] input_process_data_wp_r, input_process_data_rp_r, output_process_data_wp_r, output_process_data_rp_r;
    logic [EFPD_PTR_W:0] input_process_data_wp_nxt, input_process_data_rp_nxt, output_process_data_wp_nxt, output_process_data_rp_nxt;
    logic input_process_data_full, input_process_data_empty, output_process_data_full, output_process_data_empty, input_process_data_push, input_process_data_pop, output_process_data_push, output_process_data_pop;

    assign byte_in = {shift_r[6:0], mosi_s};
    assign byte_done = cs_act && sclk_rise && (bit_cnt_r == 3'h7);
    assign wr_stb = byte_done && (st_r == EFPD_SPI_DATA) && !rd_r;
    assign rd_load = cs_act && sclk_fall && load_pend_r;

    // spi framing: first byte is rw flag and address, then data bytes
    always_comb begin
        st_nxt = st_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        load_pend_nxt = load_pend_r;
        tx_nxt = tx_r;
        if (!cs_act) begin
            st_nxt = EFPD_SPI_ADDR;
            bit_cnt_nxt = 3'h0;
            load_pend_nxt = 1'b0;
        end else begin
            if (sclk_rise) begin
                shift_nxt = byte_in;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
            end
            if (byte_done) begin
                if (st_r == EFPD_SPI_ADDR) begin
                    st_nxt = EFPD_SPI_DATA;
                    addr_nxt = byte_in[6:0];
                    rd_nxt = byte_in[EFPD_SPI_RW_BIT];
                    load_pend_nxt = byte_in[EFPD_SPI_RW_BIT];
                end else begin
                    load_pend_nxt = rd_r;
                    if (rd_r && addr_r == EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT) begin
                        addr_nxt = addr_r;
                    end else if (!rd_r && addr_r == EFPD_ADDR_INPUT_PROCESS_DATA_PORT) begin
                        addr_nxt = addr_r;
                    end else begin
                        addr_nxt = addr_r + 7'h1;
                    end
                end
            end
            // data shifts out on falling edges; a pending load replaces the shift
            if (rd_load) begin
                tx_nxt = rd_data;
                load_pend_nxt = 1'b0;
            end else if (sclk_fall) begin
                tx_nxt = {tx_r[6:0], 1'b0};
            end
        end
    end

    // read mux; reading the output data port pops one byte
    always_comb begin
        if (addr_r == EFPD_ADDR_WDG_CODE) begin
            rd_data = wdg_code_r;
        end else if (addr_r == EFPD_ADDR_STATUS_DEF) begin
            rd_data = status_def_r;
        end else if (addr_r == EFPD_ADDR_STATUS_CODE) begin
            rd_data = status_r;
        end else if (addr_r == EFPD_ADDR_EVENT_CODE_LOW) begin
            rd_data = event_low_r;
        end else if (addr_r == EFPD_ADDR_EVENT_FLAG) begin
            rd_data = {6'h00, wdg_en_r, flag_r};
        end else if (addr_r == EFPD_ADDR_PD_VALIDITY) begin
            rd_data = {7'h00, invalid_r};
        end else if (addr_r == EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT && !output_process_data_empty) begin
            rd_data = output_process_data_mem[output_process_data_rp_r[EFPD_PTR_W-1:0]];
        end else begin
            rd_data = EFPD_RESET_BYTE;
        end
    end

    always_comb begin
        event_low_nxt = event_low_r;
        wdg_code_nxt = wdg_code_r;
        status_def_nxt = status_def_r;
        status_nxt = status_r;
        flag_nxt = flag_r;
        wdg_en_nxt = wdg_en_r;
        invalid_nxt = invalid_r;
        if (wr_stb) begin
            if (addr_r == EFPD_ADDR_WDG_CODE) begin
                wdg_code_nxt = byte_in;
            end else if (addr_r == EFPD_ADDR_STATUS_DEF) begin
                status_def_nxt = byte_in;
            end else if (addr_r == EFPD_ADDR_STATUS_CODE) begin
                status_nxt = byte_in;
            end else if (addr_r == EFPD_ADDR_EVENT_CODE_LOW) begin
                event_low_nxt = byte_in;
            end else if (addr_r == EFPD_ADDR_EVENT_FLAG) begin
                flag_nxt = byte_in[EFPD_BIT_EVENT_FLAG];
                wdg_en_nxt = byte_in[EFPD_BIT_WDG_ENABLE];
            end else if (addr_r == EFPD_ADDR_PD_VALIDITY) begin
                invalid_nxt = byte_in[EFPD_BIT_PD_INVALID];
            end
        end
        if (master_status_wr) begin
            status_nxt = master_status_data;
            flag_nxt = 1'b0;
        end
        // expiry is applied last so its set beats any clear in the same cycle
        if (watchdog_expired && wdg_en_r) begin
            status_nxt = wdg_code_r;
            flag_nxt = 1'b1;
        end
    end

    // buffers: pushes into a full buffer are dropped, pops from empty ones return zero
    assign input_process_data_full = (input_process_data_wp_r[EFPD_PTR_W] != input_process_data_rp_r[EFPD_PTR_W]) &&
                       (input_process_data_wp_r[EFPD_PTR_W-1:0] == input_process_data_rp_r[EFPD_PTR_W-1:0]);
    assign input_process_data_empty = input_process_data_wp_r == input_process_data_rp_r;
    assign output_process_data_full = (output_process_data_wp_r[EFPD_PTR_W] != output_process_data_rp_r[EFPD_PTR_W]) &&
                        (output_process_data_wp_r[EFPD_PTR_W-1:0] == output_process_data_rp_r[EFPD_PTR_W-1:0]);
    assign output_process_data_empty = output_process_data_wp_r == output_process_data_rp_r;
    assign input_process_data_push = wr_stb && addr_r == EFPD_ADDR_INPUT_PROCESS_DATA_PORT && !input_process_data_full;
    assign input_process_data_pop = input_data_pop && !input_process_data_empty;
    assign output_process_data_push = output_data_push && !output_process_data_full;
    assign output_process_data_pop = rd_load && addr_r == EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT && !output_process_data_empty;

    always_comb begin
        input_process_data_wp_nxt = input_process_data_wp_r + (EFPD_PTR_W+1)'(input_process_data_push);
        input_process_data_rp_nxt = input_process_data_rp_r + (EFPD_PTR_W+1)'(input_process_data_pop);
        output_process_data_wp_nxt = output_process_data_wp_r + (EFPD_PTR_W+1)'(output_process_data_push);
        output_process_data_rp_nxt = output_process_data_rp_r + (EFPD_PTR_W+1)'(output_process_data_pop);
        input_process_data_out_nxt = input_process_data_out_r;
        if (input_data_pop) begin
            if (pin_to_input_data_route) begin
                input_process_data_out_nxt = {7'h00, aux_s};
            end else if (invalid_r) begin
                input_process_data_out_nxt = EFPD_RESET_BYTE;
            end else if (!input_process_data_empty) begin
                input_process_data_out_nxt = input_process_data_mem[input_process_data_rp_r[EFPD_PTR_W-1:0]];
            end else begin
                input_process_data_out_nxt = EFPD_RESET_BYTE;
            end
        end
    end

    // storage arrays carry no reset so they map to plain memory
    always_ff @(posedge clock) begin
        if (input_process_data_push) begin
            input_process_data_mem[input_process_data_wp_r[EFPD_PTR_W-1:0]] <= byte_in;
        end
        if (output_process_data_push) begin
            output_process_data_mem[output_process_data_wp_r[EFPD_PTR_W-1:0]] <= output_process_data_byte;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            st_r <= EFPD_SPI_ADDR;
            bit_cnt_r <= 3'h0;
            shift_r <= EFPD_RESET_BYTE;
            tx_r <= EFPD_RESET_BYTE;
            addr_r <= 7'h00;
            rd_r <= 1'b0;
            load_pend_r <= 1'b0;
            event_low_r <= EFPD_RESET_BYTE;
            wdg_code_r <= EFPD_RESET_BYTE;
            status_def_r <= EFPD_RESET_BYTE;
            status_r <= EFPD_RESET_BYTE;
            flag_r <= 1'b0;
            wdg_en_r <= 1'b0;
            invalid_r <= 1'b0;
            input_process_data_out_r <= EFPD_RESET_BYTE;
            input_process_data_wp_r <= '0;
            input_process_data_rp_r <= '0;
            output_process_data_wp_r <= '0;
            output_process_data_rp_r <= '0;
        end else begin
            st_r <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            load_pend_r <= load_pend_nxt;
            event_low_r <= event_low_nxt;
            wdg_code_r <= wdg_code_nxt;
            status_def_r <= status_def_nxt;
            status_r <= status_nxt;
            flag_r <= flag_nxt;
            wdg_en_r <= wdg_en_nxt;
            invalid_r <= invalid_nxt;
            input_process_data_out_r <= input_process_data_out_nxt;
            input_process_data_wp_r <= input_process_data_wp_nxt;
            input_process_data_rp_r <= input_process_data_rp_nxt;
            output_process_data_wp_r <= output_process_data_wp_nxt;
            output_process_data_rp_r <= output_process_data_rp_nxt;
        end
    end

    assign spi_miso = tx_r[7];
    assign spi_miso_oe_n = !(cs_act && rd_r && st_r == EFPD_SPI_DATA);
    assign cks_event_flag = flag_r;
    assign cks_pd_invalid = invalid_r;
    assign event_memory_byte0 = flag_r ? status_r : status_def_r;
    assign event_code_low_octet = event_low_r;
    assign input_process_data_byte = input_process_data_out_r;
    assign input_data_empty = input_process_data_empty;
    assign output_data_full = output_process_data_full;
endmodule // efpd_regs

//--- efpd_regs_chk.sv
// assertion checker for the event flag and process data registers
`timescale 1ns/1ps
module efpd_regs_chk (
    input wire logic clock, // clock
    input wire logic reset_n, // reset
    input wire logic spi_cs_n, // select
    input wire logic spi_miso_oe_n, // miso enable
    input wire logic pin_to_input_data_route, // route
    input wire logic watchdog_expired, // expiry
    input wire logic master_status_wr, // master write
    input wire logic input_data_pop, // pop
    input wire logic [7:0] input_process_data_byte, // popped byte
    input wire logic cks_event_flag, // flag
    input wire logic cks_pd_invalid, // invalid
    input wire logic [7:0] event_memory_byte0 // memory byte
);
    logic [2:0] idle_r;
    logic quiet;
    // spi writes land clocks after the pins, so wait them out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) idle_r <= 3'h0;
        else idle_r <= !spi_cs_n ? 3'h0 : (idle_r == 3'h7 ? idle_r : idle_r + 3'h1);
    end
    assign quiet = spi_cs_n && idle_r >= 3'h6;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_master_clear: assert property (quiet && master_status_wr && !watchdog_expired |=> !cks_event_flag)
        else $error("flag kept after master write");
    a_pop_invalid: assert property (input_data_pop && cks_pd_invalid && !pin_to_input_data_route
        |=> input_process_data_byte == 8'h00) else $error("invalid data not zero");
    a_route_pin: assert property (input_data_pop && pin_to_input_data_route |=> input_process_data_byte[7:1] == 7'h00)
        else $error("routed byte has upper bits");
    a_byte_hold: assert property (!input_data_pop |=> $stable(input_process_data_byte))
        else $error("input byte moved without pop");
    a_flag_quiet: assert property (quiet && !watchdog_expired && !master_status_wr |=> $stable(cks_event_flag))
        else $error("flag moved without cause");
    a_invalid_quiet: assert property (quiet |=> $stable(cks_pd_invalid))
        else $error("invalid bit moved without write");
    a_default_steady: assert property (quiet && !cks_event_flag && !watchdog_expired |=> $stable(event_memory_byte0))
        else $error("memory byte moved");
    a_miso_idle: assert property (quiet |-> spi_miso_oe_n)
        else $error("miso driven while idle");
endmodule // efpd_regs_chk
bind efpd_regs efpd_regs_chk u_chk (.clock, .reset_n, .spi_cs_n, .spi_miso_oe_n, .pin_to_input_data_route,
    .watchdog_expired, .master_status_wr, .input_data_pop, .input_process_data_byte, .cks_event_flag,
    .cks_pd_invalid, .event_memory_byte0);

//--- test_efpd_regs.sv
// self-checking bench for the event flag and process data registers
`timescale 1ns/1ps
module test_efpd_regs;
    import efpd_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, input_data_empty, output_data_full;
    logic aux_pin_one = 0, pin_to_input_data_route = 0, watchdog_expired = 0, master_status_wr = 0;
    logic input_data_pop = 0, output_data_push = 0, cks_event_flag, cks_pd_invalid;
    logic [7:0] master_status_data = 0, output_process_data_byte = 0, input_process_data_byte;
    logic [7:0] event_memory_byte0, event_code_low_octet, rx, val, v, w, d;
    logic [7:0] q[$];
    logic [6:0] regs[6] = '{EFPD_ADDR_EVENT_CODE_LOW, EFPD_ADDR_EVENT_FLAG, EFPD_ADDR_INPUT_PROCESS_DATA_PORT,
        EFPD_ADDR_PD_VALIDITY, EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT, 7'h31};
    logic [31:0] seed = 32'h235;
    int num_errors = 0, n_compared = 0, n;
    always #25 clock = ~clock;
    efpd_regs u_dut (
        .clock(clock),
        .reset_n(reset_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n),
        .aux_pin_one(aux_pin_one),
        .pin_to_input_data_route(pin_to_input_data_route),
        .watchdog_expired(watchdog_expired),
        .master_status_wr(master_status_wr),
        .master_status_data(master_status_data),
        .input_data_pop(input_data_pop),
        .input_process_data_byte(input_process_data_byte),
        .input_data_empty(input_data_empty),
        .output_data_push(output_data_push),
        .output_process_data_byte(output_process_data_byte),
        .output_data_full(output_data_full),
        .cks_event_flag(cks_event_flag),
        .cks_pd_invalid(cks_pd_invalid),
        .event_memory_byte0(event_memory_byte0),
        .event_code_low_octet(event_code_low_octet)
    );
    efpd_mcu_model u_mcu (.clock, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_in(input logic rt, input logic iv, input logic ax, input logic [7:0] hd);
        return rt ? {7'h00, ax} : (iv ? 8'h00 : hd);
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] dt);
        u_mcu.open_frame();
        u_mcu.xfer({1'b0, a}, rx);
        u_mcu.xfer(dt, rx);
        u_mcu.close_frame();
    endtask
    task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
        u_mcu.open_frame();
        u_mcu.xfer({1'b1, a}, rx);
        u_mcu.xfer(8'h00, val);
        u_mcu.close_frame();
        chk(name, exp, val);
    endtask
    task automatic link(input logic wd, input logic m, input logic [7:0] dt);
        @(negedge clock);
        watchdog_expired = wd;
        master_status_wr = m;
        master_status_data = dt;
        @(negedge clock);
        watchdog_expired = 1'b0;
        master_status_wr = 1'b0;
        @(negedge clock);
    endtask
    task automatic pop_chk(input logic [7:0] exp);
        @(negedge clock);
        input_data_pop = 1'b1;
        @(negedge clock);
        input_data_pop = 1'b0;
        chk("input byte", exp, input_process_data_byte);
    endtask
    // burst read of the output port: queued bytes in order, then zero once empty
    task automatic output_process_data_burst(input int cnt);
        u_mcu.open_frame();
        u_mcu.xfer({1'b1, EFPD_ADDR_OUTPUT_PROCESS_DATA_PORT}, rx);
        for (int i = 0; i <= cnt; i++) begin
            u_mcu.xfer(8'h00, rx);
            chk("output byte", i < cnt ? q[i] : 8'h00, rx);
        end
        u_mcu.close_frame();
        q.delete();
    endtask
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        foreach (regs[i]) rdchk("reset value", regs[i], 8'h00);
        v = rnd();
        wr(EFPD_ADDR_EVENT_CODE_LOW, v);
        rdchk("code read", EFPD_ADDR_EVENT_CODE_LOW, v);
        chk("code output", v, event_code_low_octet);
        d = rnd();
        wr(EFPD_ADDR_STATUS_DEF, d);
        chk("memory default", d, event_memory_byte0);
        wr(EFPD_ADDR_EVENT_FLAG, 8'h01);
        chk("flag set", 8'h01, {7'h00, cks_event_flag});
        v = rnd();
        link(1'b0, 1'b1, v);
        chk("flag cleared", 8'h00, {7'h00, cks_event_flag});
        w = rnd();
        wr(EFPD_ADDR_WDG_CODE, w);
        link(1'b1, 1'b0, 8'h00);
        chk("expiry disabled", d, event_memory_byte0);
        wr(EFPD_ADDR_EVENT_FLAG, 8'h01);
        chk("status kept", v, event_memory_byte0);
        wr(EFPD_ADDR_EVENT_FLAG, 8'h02);
        link(1'b1, 1'b0, 8'h00);
        chk("expiry code", w, event_memory_byte0);
        rdchk("status read", EFPD_ADDR_STATUS_CODE, w);
        rdchk("watchdog code", EFPD_ADDR_WDG_CODE, w);
        rdchk("flag register", EFPD_ADDR_EVENT_FLAG, 8'h03);
        link(1'b1, 1'b1, ~w);
        chk("set wins", 8'h01, {7'h00, cks_event_flag});
        v = rnd();
        wr(EFPD_ADDR_INPUT_PROCESS_DATA_PORT, v);
        wr(EFPD_ADDR_PD_VALIDITY, 8'h01);
        chk("cks invalid", 8'h01, {7'h00, cks_pd_invalid});
        pop_chk(exp_in(1'b0, 1'b1, 1'b0, v));
        pin_to_input_data_route = 1'b1;
        for (int i = 0; i < 2; i++) begin
            aux_pin_one = ~aux_pin_one;
            repeat (4) @(negedge clock);
            pop_chk(exp_in(1'b1, 1'b1, aux_pin_one, v));
        end
        pin_to_input_data_route = 1'b0;
        wr(EFPD_ADDR_PD_VALIDITY, 8'h00);
        chk("cks valid", 8'h00, {7'h00, cks_pd_invalid});
        repeat (4) begin
            @(negedge clock);
            input_data_pop = ~input_data_empty;
        end
        for (int r = 0; r < 3; r++) begin
            n = int'(rnd() % 8'h04) + 1;
            u_mcu.open_frame();
            u_mcu.xfer({1'b0, EFPD_ADDR_INPUT_PROCESS_DATA_PORT}, rx);
            for (int i = 0; i < n; i++) begin
                q.push_back(rnd());
                u_mcu.xfer(q[$], rx);
            end
            u_mcu.close_frame();
            chk("input empty", 8'h00, {7'h00, input_data_empty});
            while (q.size() > 0) pop_chk(exp_in(1'b0, 1'b0, 1'b0, q.pop_front()));
            pop_chk(8'h00);
            chk("input empty", 8'h01, {7'h00, input_data_empty});
            for (int i = 0; i < n; i++) begin
                @(negedge clock);
                output_data_push = 1'b1;
                output_process_data_byte = rnd();
                q.push_back(output_process_data_byte);
            end
            @(negedge clock);
            output_data_push = 1'b0;
            chk("output full", 8'h00, {7'h00, output_data_full});
            output_process_data_burst(n);
        end
        // fill to the brim; the extra byte must be dropped, not overwrite the head
        for (int i = 0; i <= EFPD_FIFO_DEPTH; i++) begin
            @(negedge clock);
            chk("output full", i == EFPD_FIFO_DEPTH ? 8'h01 : 8'h00, {7'h00, output_data_full});
            output_data_push = 1'b1;
            output_process_data_byte = rnd();
            if (i < EFPD_FIFO_DEPTH) q.push_back(output_process_data_byte);
        end
        @(negedge clock);
        output_data_push = 1'b0;
        output_process_data_burst(EFPD_FIFO_DEPTH);
        final_report();
    end
endmodule // test_efpd_regs
